// ---- hdl/vss_pkg.sv ----
// vss_pkg: command codes, field positions, reset values, timing and types
// for the output setpoint sequencer; assumes a 10 MHz single clock.
package vss_pkg;
	// command codes
	localparam logic [7:0] CMD_OPERATION = 8'h01;
	localparam logic [7:0] CMD_ONOFF = 8'h02;
	localparam logic [7:0] CMD_VOUT = 8'h21;
	localparam logic [7:0] CMD_TRIM = 8'h22;
	localparam logic [7:0] CMD_VMAX = 8'h24;
	localparam logic [7:0] CMD_RATE = 8'h27;
	localparam logic [7:0] CMD_VMIN = 8'h28;
	localparam logic [7:0] CMD_SCALE = 8'h29;
	localparam logic [7:0] CMD_INPUT_TURNON_THRESHOLD = 8'h35;
	localparam logic [7:0] CMD_INPUT_TURNOFF_THRESHOLD = 8'h36;
	localparam logic [7:0] CMD_TON = 8'h60;
	localparam logic [7:0] CMD_TOFF = 8'h64;
	localparam logic [7:0] CMD_VSTAT = 8'h7A;
	localparam logic [7:0] CMD_MSTAT = 8'h80;
	localparam logic [7:0] CMD_RDBK = 8'h8B;
	localparam logic [7:0] CMD_MHI = 8'hD5;
	localparam logic [7:0] CMD_MLO = 8'hD6;
	localparam logic [7:0] CMD_OPT = 8'hE5;
	// reference codes, 2^-9 V per step
	localparam logic [11:0] DAC_MIN = 12'h0B3;
	localparam logic [11:0] DAC_MAX = 12'h34D;
	localparam logic [11:0] SC1_MIN = 12'h0B3;
	localparam logic [11:0] SC1_MAX = 12'h34D;
	localparam logic [11:0] SC2_MIN = 12'h166;
	localparam logic [11:0] SC2_MAX = 12'h69A;
	localparam logic [11:0] SC4_MIN = 12'h2CC;
	localparam logic [11:0] SC4_MAX = 12'hB00;
	localparam logic [1:0] SCALE_ILLEGAL = 2'h3;
	// input thresholds in 1/16 V: 4 V floor, 7.75 V ceiling
	localparam logic [15:0] INPUT_TURNOFF_THRESHOLD_FLOOR = 16'h0040;
	localparam logic [15:0] INPUT_TURNON_THRESHOLD_CEIL = 16'h007C;
	localparam logic [6:0] DELAY_MAX_MS = 7'h64;
	localparam logic [7:0] TRIM_MIN = 8'hC0;
	localparam logic [7:0] TRIM_MAX = 8'h3F;
	localparam logic [7:0] MARG_MAX = 8'h1F;
	// field positions
	localparam int OPR_ON_BIT = 7;
	localparam int OPR_MARG_LSB = 4;
	localparam int CFG_USE_PIN = 0;
	localparam int CFG_USE_OPR = 1;
	localparam int OPT_RESTORE_BIT = 0;
	localparam int VSTAT_MAX_BIT = 3;
	localparam int VSTAT_MIN_BIT = 4;
	localparam int MSTAT_RST_BIT = 0;
	// reset values
	localparam logic [7:0] OPR_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h01;
	localparam logic [15:0] VON_RST = 16'h0070;
	localparam logic [15:0] VOFF_RST = 16'h0060;
	localparam logic [7:0] RATE_RST = 8'h01;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_NS = 1000000;
	localparam int RST_RESP_NS = 2000;
	localparam int RST_RESP_CYC = RST_RESP_NS / CLK_PERIOD_NS;
	localparam int RATE_TICK_NS = 10000;
	localparam int RATE_TICK_CYC = RATE_TICK_NS / CLK_PERIOD_NS;
	localparam int AVG_LOG2 = 3;

	typedef enum logic [1:0] {MARG_NONE = 2'b00, MARG_LOW = 2'b01, MARG_HIGH = 2'b10} vss_marg_t;
	typedef enum logic [1:0] {SEQ_OFF = 2'b00, SEQ_ON_DLY = 2'b01, SEQ_RUN = 2'b10,
		SEQ_OFF_DLY = 2'b11} vss_seq_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] code;
		logic [15:0] wdata;
	} vss_req_t;

	typedef struct packed {
		logic [11:0] cmd, vmax, vmin, boot, ref_code, tgt_prev, rdbk;
		logic [1:0] scale;
		logic [15:0] von, voff, opt, rdata, rcnt, mscnt;
		logic [7:0] opr, cfg, rate, trim, mhi, mlo, vstat, mstat;
		logic [6:0] ton, toff, dly;
		logic booted, uvlo_ok, regulate;
		vss_seq_t seq;
		logic [14:0] acc;
		logic [2:0] nsamp;
	} vss_st_t;

	function automatic logic [11:0] vss_clamp(input logic signed [13:0] v,
		input logic [11:0] lo, input logic [11:0] hi);
		if (v < $signed({2'b00, lo}))
			vss_clamp = lo;
		else if (v > $signed({2'b00, hi}))
			vss_clamp = hi;
		else
			vss_clamp = v[11:0];
	endfunction : vss_clamp

	function automatic logic [7:0] vss_sat8(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		if ($signed(v) < $signed(lo))
			vss_sat8 = lo;
		else if ($signed(v) > $signed(hi))
			vss_sat8 = hi;
		else
			vss_sat8 = v;
	endfunction : vss_sat8
endpackage : vss_pkg

// ---- hdl/vss_top.sv ----
// vss_top: setpoint, sequencing and telemetry core of a buck converter.
// assumes bus commands arrive already decoded as one-cycle requests and
// all pins are synchronous to ref_clk.
// What this block does
// - separate input turn-on/turn-off thresholds; off floor 4 V, on ceiling 7.75 V.
// - configuration picks gating: input lockout, plus control pin, plus operation.
// - after gating goes true wait programmable 0..100 ms, then regulate.
// - after gating goes false keep regulating for programmable delay up to 100 ms.
// - reference DAC spans 350..1650 mV in 2^-9 V steps.
// - sensed output samples are averaged; latest average kept for readback.
// - scale setting only takes 1, 0.5 or 0.25; default is 1.
// - command code range depends on scale: 179..845, 358..1690, 716..2816.
// - command beyond stored min or max is replaced by that limit, status set.
// - signed trim of -64..+63 steps added to reference.
// - margin high and low offsets each hold -64..31 steps.
// - operation picks none, high or low margin; that offset gets applied.
// - summed reference is limited to the DAC span.
// - reset pin low loads command with the power-up default value.
// - within 2 us of pin falling, ramp toward default begins.
// - command writes ignored while the reset pin is low.
// - setpoint reset sets a bit in the maker status register.
// - option bit set restores boot command on every fault restart.
`timescale 1ns/1ns
module vss_top
	import vss_pkg::*;
#(
	parameter int CYC_PER_MS = MS_NS / CLK_PERIOD_NS
)(
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// decoded command port
	input wire vss_req_t reg_req,
	output logic [15:0] reg_rdata,
	// pins and sensed values
	input wire logic [15:0] vin_code,
	input wire logic enable_control_pin,
	input wire logic setpoint_reset_pin_n,
	input wire logic [11:0] boot_setpoint,
	input wire logic [11:0] sensed_output_node,
	input wire logic sense_valid,
	input wire logic fault_restart,
	// converter controls
	output logic [11:0] ref_dac,
	output logic regulate
);
	localparam int RESP_CYC = RST_RESP_CYC;

	vss_st_t r, n;
	logic pin_low, gate, ms_tick;
	logic [11:0] wval, lim, smin, smax, tgt;
	logic [7:0] marg, vset, mset;
	logic [15:0] vclr, mclr;
	logic signed [13:0] sum;

	assign pin_low = !setpoint_reset_pin_n;
	assign wval = reg_req.wdata[11:0];

	always_comb
	begin
		n = r;
		vset = 8'h00;
		mset = 8'h00;
		vclr = 16'h0000;
		mclr = 16'h0000;
		lim = wval;
		unique case (r.scale)
			2'h1: begin smin = SC2_MIN; smax = SC2_MAX; end
			2'h2: begin smin = SC4_MIN; smax = SC4_MAX; end
			default: begin smin = SC1_MIN; smax = SC1_MAX; end
		endcase
		// strap caught on the first clock after reset release
		if (!r.booted)
		begin
			n.booted = 1'b1;
			n.boot = boot_setpoint;
			n.cmd = boot_setpoint;
		end
		// bus rate sits far below ref_clk, so one request per cycle is ample
		if (reg_req.wr)
		begin
			unique case (reg_req.code)
				CMD_VOUT:
					if (!pin_low)
					begin
						if (wval < r.vmin)
						begin
							lim = r.vmin;
							vset[VSTAT_MIN_BIT] = 1'b1;
						end
						else if (wval > r.vmax)
						begin
							lim = r.vmax;
							vset[VSTAT_MAX_BIT] = 1'b1;
						end
						n.cmd = vss_clamp($signed({2'b00, lim}), smin, smax);
					end
				CMD_VMAX: n.vmax = vss_clamp($signed({2'b00, wval}), smin, smax);
				CMD_VMIN: n.vmin = vss_clamp($signed({2'b00, wval}), smin, smax);
				CMD_SCALE:
					if (reg_req.wdata[1:0] != SCALE_ILLEGAL)
						n.scale = reg_req.wdata[1:0];
				CMD_INPUT_TURNON_THRESHOLD:
					n.von = (reg_req.wdata > INPUT_TURNON_THRESHOLD_CEIL) ? INPUT_TURNON_THRESHOLD_CEIL : reg_req.wdata;
				CMD_INPUT_TURNOFF_THRESHOLD:
					n.voff = (reg_req.wdata < INPUT_TURNOFF_THRESHOLD_FLOOR) ? INPUT_TURNOFF_THRESHOLD_FLOOR : reg_req.wdata;
				CMD_OPERATION: n.opr = reg_req.wdata[7:0];
				CMD_ONOFF: n.cfg = reg_req.wdata[7:0];
				CMD_TON:
					n.ton = (reg_req.wdata > 16'(DELAY_MAX_MS)) ? DELAY_MAX_MS : reg_req.wdata[6:0];
				CMD_TOFF:
					n.toff = (reg_req.wdata > 16'(DELAY_MAX_MS)) ? DELAY_MAX_MS : reg_req.wdata[6:0];
				CMD_RATE: n.rate = (reg_req.wdata[7:0] == 8'h00) ? RATE_RST : reg_req.wdata[7:0];
				CMD_TRIM: n.trim = vss_sat8(reg_req.wdata[7:0], TRIM_MIN, TRIM_MAX);
				CMD_MHI: n.mhi = vss_sat8(reg_req.wdata[7:0], TRIM_MIN, MARG_MAX);
				CMD_MLO: n.mlo = vss_sat8(reg_req.wdata[7:0], TRIM_MIN, MARG_MAX);
				CMD_OPT: n.opt = reg_req.wdata;
				CMD_VSTAT: vclr = reg_req.wdata;
				CMD_MSTAT: mclr = reg_req.wdata;
				default: ;
			endcase
		end
		// pin reset and fault restart override any bus value this cycle
		if (pin_low && r.booted)
		begin
			n.cmd = r.boot;
			mset[MSTAT_RST_BIT] = 1'b1;
		end
		else if (fault_restart && r.opt[OPT_RESTORE_BIT] && r.booted)
			n.cmd = r.boot;
		// set wins over a write-one clear in the same cycle
		n.vstat = (r.vstat & ~vclr[7:0]) | vset;
		n.mstat = (r.mstat & ~mclr[7:0]) | mset;
		// lockout with hysteresis between the two thresholds
		if (vin_code >= r.von)
			n.uvlo_ok = 1'b1;
		else if (vin_code < r.voff)
			n.uvlo_ok = 1'b0;
		gate = r.uvlo_ok && (!r.cfg[CFG_USE_PIN] || enable_control_pin)
			&& (!r.cfg[CFG_USE_OPR] || r.opr[OPR_ON_BIT]);
		ms_tick = (r.mscnt == 16'h0000);
		n.mscnt = ms_tick ? 16'(CYC_PER_MS - 1) : r.mscnt - 16'h0001;
		// delays resolve to whole ms ticks; entry reloads the ms counter, so the first tick comes a full ms later
		unique case (r.seq)
			SEQ_OFF:
				if (gate)
				begin
					n.seq = SEQ_ON_DLY;
					n.dly = r.ton;
					n.mscnt = 16'(CYC_PER_MS - 1);
				end
			SEQ_ON_DLY:
				if (!gate)
					n.seq = SEQ_OFF;
				else if (r.dly == 7'h00)
					n.seq = SEQ_RUN;
				else if (ms_tick)
					n.dly = r.dly - 7'h01;
			SEQ_RUN:
				if (!gate)
				begin
					n.seq = SEQ_OFF_DLY;
					n.dly = r.toff;
					n.mscnt = 16'(CYC_PER_MS - 1);
				end
			SEQ_OFF_DLY:
				if (gate)
					n.seq = SEQ_RUN;
				else if (r.dly == 7'h00)
					n.seq = SEQ_OFF;
				else if (ms_tick)
					n.dly = r.dly - 7'h01;
		endcase
		n.regulate = (n.seq == SEQ_RUN) || (n.seq == SEQ_OFF_DLY);
		// reference target: scaled command plus margin and trim, then span limit
		unique case (vss_marg_t'(r.opr[OPR_MARG_LSB +: 2]))
			MARG_HIGH: marg = r.mhi;
			MARG_LOW: marg = r.mlo;
			default: marg = 8'h00;
		endcase
		sum = $signed({2'b00, r.cmd >> r.scale}) + 14'($signed(marg))
			+ 14'($signed(r.trim));
		tgt = vss_clamp(sum, DAC_MIN, DAC_MAX);
		// new target restarts the step timer so the ramp begins next cycle
		if (tgt != r.tgt_prev)
		begin
			n.tgt_prev = tgt;
			n.rcnt = 16'h0000;
		end
		else if (r.rcnt != 16'h0000)
			n.rcnt = r.rcnt - 16'h0001;
		else if (r.ref_code != tgt)
		begin
			n.ref_code = (r.ref_code < tgt) ? r.ref_code + 12'h001 : r.ref_code - 12'h001;
			n.rcnt = 16'(r.rate * RATE_TICK_CYC) - 16'h0001;
		end
		// block average of each 2^AVG_LOG2 samples
		if (sense_valid)
		begin
			if (r.nsamp == 3'h7)
			begin
				n.rdbk = 12'((r.acc + 15'(sensed_output_node)) >> AVG_LOG2);
				n.acc = 15'h0000;
			end
			else
				n.acc = r.acc + 15'(sensed_output_node);
			n.nsamp = r.nsamp + 3'h1;
		end
		n.rdata = 16'h0000;
		if (reg_req.rd)
		begin
			unique case (reg_req.code)
				CMD_VOUT: n.rdata = 16'(r.cmd);
				CMD_VMAX: n.rdata = 16'(r.vmax);
				CMD_VMIN: n.rdata = 16'(r.vmin);
				CMD_SCALE: n.rdata = 16'(r.scale);
				CMD_INPUT_TURNON_THRESHOLD: n.rdata = r.von;
				CMD_INPUT_TURNOFF_THRESHOLD: n.rdata = r.voff;
				CMD_OPERATION: n.rdata = 16'(r.opr);
				CMD_ONOFF: n.rdata = 16'(r.cfg);
				CMD_TON: n.rdata = 16'(r.ton);
				CMD_TOFF: n.rdata = 16'(r.toff);
				CMD_RATE: n.rdata = 16'(r.rate);
				CMD_TRIM: n.rdata = 16'(r.trim);
				CMD_MHI: n.rdata = 16'(r.mhi);
				CMD_MLO: n.rdata = 16'(r.mlo);
				CMD_OPT: n.rdata = r.opt;
				CMD_VSTAT: n.rdata = 16'(r.vstat);
				CMD_MSTAT: n.rdata = 16'(r.mstat);
				CMD_RDBK: n.rdata = 16'(r.rdbk);
				default: n.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			r <= '0;
			r.vmax <= SC1_MAX;
			r.vmin <= SC1_MIN;
			r.von <= VON_RST;
			r.voff <= VOFF_RST;
			r.opr <= OPR_RST;
			r.cfg <= CFG_RST;
			r.rate <= RATE_RST;
			r.ref_code <= DAC_MIN;
			r.tgt_prev <= DAC_MIN;
			r.seq <= SEQ_OFF;
		end
		else
			r <= n;
	end

	assign reg_rdata = r.rdata;
	assign ref_dac = r.ref_code;
	assign regulate = r.regulate;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// checks sleep through srst; $past right after release sees reset values

	a_thresh_bounds: assert property (r.von <= INPUT_TURNON_THRESHOLD_CEIL && r.voff >= INPUT_TURNOFF_THRESHOLD_FLOOR)
		else $error("input threshold outside bounds");
	a_gate_start: assert property ((r.seq == SEQ_OFF && gate) |=> r.seq == SEQ_ON_DLY)
		else $error("gating did not start turn-on delay");
	a_delay_bound: assert property (r.dly <= DELAY_MAX_MS)
		else $error("delay count above limit");
	a_off_delay: assert property ((r.seq == SEQ_RUN && !gate)
		|=> (r.seq == SEQ_OFF_DLY && regulate))
		else $error("regulation stopped without turn-off delay");
	a_dac_span: assert property (ref_dac >= DAC_MIN && ref_dac <= DAC_MAX)
		else $error("reference outside DAC span");
	a_scale_legal: assert property (r.scale != SCALE_ILLEGAL)
		else $error("illegal scale setting");
	a_avg_wrap: assert property ((sense_valid && r.nsamp == 3'h7)
		|=> (r.acc == 15'h0000 && r.nsamp == 3'h0))
		else $error("average window did not close");
	a_trim_range: assert property ($signed(r.trim) >= $signed(TRIM_MIN)
		&& $signed(r.mhi) <= $signed(MARG_MAX) && $signed(r.mlo) <= $signed(MARG_MAX))
		else $error("offset outside range");
	a_max_clamp: assert property ((reg_req.wr && reg_req.code == CMD_VOUT && !pin_low
		&& wval > r.vmax && r.booted) |=> (r.vstat[VSTAT_MAX_BIT] && r.cmd <= $past(r.vmax)))
		else $error("command above max not clamped");
	a_pin_restore: assert property ((pin_low && r.booted)
		|=> (r.cmd == $past(r.boot) && r.mstat[MSTAT_RST_BIT]))
		else $error("reset pin did not restore default");
	// a new target restarts the step timer, so the first step never waits a full rate period
	a_ramp_begin: assert property (($fell(setpoint_reset_pin_n) && r.booted
		&& r.cmd != r.boot) |-> ##[1:RESP_CYC] ($changed(r.ref_code) || r.ref_code == r.tgt_prev))
		else $error("ramp did not begin in time");
	a_restart_restore: assert property ((fault_restart && !pin_low && r.opt[OPT_RESTORE_BIT]
		&& r.booted) |=> r.cmd == $past(r.boot))
		else $error("fault restart did not restore boot command");
	a_ramp_unit: assert property ($changed(r.ref_code)
		|-> (r.ref_code == $past(r.ref_code) + 12'h001
		|| r.ref_code == $past(r.ref_code) - 12'h001))
		else $error("reference moved more than one code");
	a_hold_low: assert property ((pin_low && $past(pin_low) && r.booted)
		|-> r.cmd == r.boot)
		else $error("command moved while reset pin held low");

	c_run: cover property (r.seq == SEQ_ON_DLY ##1 r.seq == SEQ_RUN);
	c_pin_reset: cover property ($fell(setpoint_reset_pin_n) && r.booted);
	c_margin_high: cover property (r.opr[OPR_MARG_LSB +: 2] == MARG_HIGH && regulate);
	c_ramp_step: cover property ($changed(r.ref_code));
	c_pin_write: cover property (pin_low && reg_req.wr && reg_req.code == CMD_VOUT);
endmodule : vss_top

// ---- dv/vss_host_model.sv ----
// vss_host_model: command-port host and pin driver facing vss_top.
// assumes requests launch 10 ns after a rising edge of ref_clk.
`timescale 1ns/1ns
module vss_host_model
	import vss_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// command port
	output vss_req_t reg_req,
	input wire logic [15:0] reg_rdata,
	// pins
	output logic enable_control_pin,
	output logic setpoint_reset_pin_n,
	output logic fault_restart
);
	initial
	begin
		reg_req = '0;
		enable_control_pin = 1'b0;
		setpoint_reset_pin_n = 1'b1;
		fault_restart = 1'b0;
	end

	// released fields show inverted values, so a stale capture is visible
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge ref_clk);
		#10;
		reg_req = '{wr: 1'b1, rd: 1'b0, code: c, wdata: d};
		@(posedge ref_clk);
		#10;
		reg_req = '{wr: 1'b0, rd: 1'b0, code: ~c, wdata: ~d};
	endtask : wr

	// data is taken in the single cycle it stands
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(posedge ref_clk);
		#10;
		reg_req = '{wr: 1'b0, rd: 1'b1, code: c, wdata: 16'hA5A5};
		@(posedge ref_clk);
		#10;
		d = reg_rdata;
		reg_req = '{wr: 1'b0, rd: 1'b0, code: ~c, wdata: 16'h5A5A};
	endtask : rd

	// a held-low reset pin does not mean writes land
	task automatic pins(input logic en, input logic rst_n);
		@(posedge ref_clk);
		#10;
		enable_control_pin = en;
		setpoint_reset_pin_n = rst_n;
	endtask : pins

	task automatic restart();
		@(posedge ref_clk);
		#10;
		fault_restart = 1'b1;
		@(posedge ref_clk);
		#10;
		fault_restart = 1'b0;
	endtask : restart
endmodule : vss_host_model

// ---- dv/tb_vss_top.sv ----
// tb_vss_top: directed checks of vss_top through its command port and pins.
// assumes CYC_PER_MS shortened to 20 and a 100 ns clock.
`timescale 1ns/1ns
module tb_vss_top
	import vss_pkg::*;
;
	logic ref_clk, srst, en_pin, rst_pin_n, fault_restart, sense_valid, regulate;
	vss_req_t reg_req;
	logic [15:0] reg_rdata, vin_code;
	logic [11:0] boot_setpoint, sensed, ref_dac;
	int err_total = 0;
	int compares = 0;
	logic [7:0] rc [9] = '{CMD_ONOFF, CMD_INPUT_TURNON_THRESHOLD, CMD_INPUT_TURNOFF_THRESHOLD, CMD_SCALE, CMD_VMAX,
		CMD_VMIN, CMD_VOUT, CMD_RATE, 8'h55};
	logic [15:0] rv [9] = '{16'h0001, 16'h0070, 16'h0060, 16'h0000, 16'h034D,
		16'h00B3, 16'h00C0, 16'h0001, 16'h0000};

	vss_top #(.CYC_PER_MS(20)) i_dut (.ref_clk(ref_clk), .srst(srst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .vin_code(vin_code), .enable_control_pin(en_pin),
		.setpoint_reset_pin_n(rst_pin_n), .boot_setpoint(boot_setpoint),
		.sensed_output_node(sensed), .sense_valid(sense_valid),
		.fault_restart(fault_restart), .ref_dac(ref_dac), .regulate(regulate));
	vss_host_model i_host (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.enable_control_pin(en_pin), .setpoint_reset_pin_n(rst_pin_n),
		.fault_restart(fault_restart));

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] c, input logic [15:0] e);
		logic [15:0] d;
		i_host.rd(c, d);
		chk(d, e);
	endtask : rchk

	task automatic bchk(input logic [7:0] c, input logic [15:0] m);
		logic [15:0] d;
		i_host.rd(c, d);
		chk(d & m, m);
	endtask : bchk

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#10;
	endtask : cyc

	task automatic finish_test();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test

	initial
	begin
		cyc(20000);
		err_total++;
		finish_test();
	end

	initial
	begin
		srst = 1'b1;
		vin_code = 16'h0078;
		boot_setpoint = 12'h0C0;
		sensed = 12'h000;
		sense_valid = 1'b0;
		cyc(4);
		srst = 1'b0;
		chk({4'h0, ref_dac}, 16'h00B3);
		chk({15'h0, regulate}, 16'h0000);
		chk(reg_rdata, 16'h0000);
		for (int i = 0; i < 9; i++)
			rchk(rc[i], rv[i]);
		$display("test reset done");
		cyc(1500);
		chk({4'h0, ref_dac}, 16'h00C0);
		i_host.wr(CMD_MHI, 16'h0005);
		i_host.wr(CMD_OPERATION, 16'h00A0);
		cyc(2);
		chk({4'h0, ref_dac}, 16'h00C1);
		cyc(600);
		chk({4'h0, ref_dac}, 16'h00C5);
		i_host.wr(CMD_MLO, 16'h00FD);
		i_host.wr(CMD_OPERATION, 16'h0090);
		cyc(900);
		chk({4'h0, ref_dac}, 16'h00BD);
		i_host.wr(CMD_OPERATION, 16'h0080);
		i_host.wr(CMD_TRIM, 16'h0002);
		cyc(600);
		chk({4'h0, ref_dac}, 16'h00C2);
		i_host.wr(CMD_TRIM, 16'h00FE);
		i_host.wr(CMD_VOUT, 16'h00B3);
		cyc(1700);
		chk({4'h0, ref_dac}, 16'h00B3);
		$display("test reference done");
		i_host.wr(CMD_TRIM, 16'h0050);
		rchk(CMD_TRIM, 16'h003F);
		i_host.wr(CMD_MHI, 16'h0040);
		rchk(CMD_MHI, 16'h001F);
		i_host.wr(CMD_MLO, 16'h0080);
		rchk(CMD_MLO, 16'h00C0);
		i_host.wr(CMD_INPUT_TURNOFF_THRESHOLD, 16'h0010);
		rchk(CMD_INPUT_TURNOFF_THRESHOLD, 16'h0040);
		i_host.wr(CMD_INPUT_TURNON_THRESHOLD, 16'h00FF);
		rchk(CMD_INPUT_TURNON_THRESHOLD, 16'h007C);
		i_host.wr(CMD_SCALE, 16'h0001);
		i_host.wr(CMD_SCALE, 16'h0003);
		rchk(CMD_SCALE, 16'h0001);
		i_host.wr(CMD_SCALE, 16'h0000);
		i_host.wr(CMD_VMAX, 16'h0400);
		rchk(CMD_VMAX, 16'h034D);
		i_host.wr(CMD_VMAX, 16'h0200);
		i_host.wr(CMD_VOUT, 16'h0300);
		rchk(CMD_VOUT, 16'h0200);
		bchk(CMD_VSTAT, 16'h0008);
		i_host.wr(CMD_VMIN, 16'h0100);
		i_host.wr(CMD_VOUT, 16'h0050);
		rchk(CMD_VOUT, 16'h0100);
		bchk(CMD_VSTAT, 16'h0010);
		i_host.wr(CMD_VSTAT, 16'h0018);
		rchk(CMD_VSTAT, 16'h0000);
		i_host.wr(CMD_RATE, 16'h0003);
		rchk(CMD_RATE, 16'h0003);
		i_host.wr(CMD_RATE, 16'h0000);
		rchk(CMD_RATE, 16'h0001);
		$display("test limits done");
		i_host.pins(1'b0, 1'b0);
		cyc(3);
		i_host.wr(CMD_VOUT, 16'h0150);
		rchk(CMD_VOUT, 16'h00C0);
		bchk(CMD_MSTAT, 16'h0001);
		i_host.pins(1'b0, 1'b1);
		i_host.wr(CMD_MSTAT, 16'h0001);
		rchk(CMD_MSTAT, 16'h0000);
		i_host.wr(CMD_OPT, 16'h0001);
		i_host.wr(CMD_VOUT, 16'h0120);
		i_host.restart();
		cyc(3);
		rchk(CMD_VOUT, 16'h00C0);
		$display("test setpoint reset done");
		for (int i = 0; i < 8; i++)
		begin
			sensed = i[0] ? 12'h108 : 12'h100;
			sense_valid = 1'b1;
			cyc(1);
			sense_valid = 1'b0;
			cyc(1);
		end
		cyc(2);
		rchk(CMD_RDBK, 16'h0104);
		$display("test telemetry done");
		i_host.wr(CMD_TON, 16'h0002);
		i_host.wr(CMD_TOFF, 16'h0003);
		// drop below turn-off so lockout is armed, then sit between thresholds
		vin_code = 16'h0030;
		cyc(2);
		vin_code = 16'h0078;
		i_host.pins(1'b1, 1'b1);
		cyc(60);
		chk({15'h0, regulate}, 16'h0000);
		vin_code = 16'h0080;
		cyc(30);
		chk({15'h0, regulate}, 16'h0000);
		cyc(15);
		chk({15'h0, regulate}, 16'h0001);
		i_host.pins(1'b0, 1'b1);
		cyc(50);
		chk({15'h0, regulate}, 16'h0001);
		cyc(20);
		chk({15'h0, regulate}, 16'h0000);
		i_host.wr(CMD_OPERATION, 16'h0000);
		i_host.wr(CMD_ONOFF, 16'h0002);
		i_host.wr(CMD_TON, 16'h0000);
		i_host.wr(CMD_OPERATION, 16'h0080);
		cyc(4);
		chk({15'h0, regulate}, 16'h0001);
		$display("test sequencing done");
		finish_test();
	end
endmodule : tb_vss_top
